// *** core/attr_map_pkg.sv ***
// constants shared by the attribute map and palette unit
package attr_map_pkg;
  // register word offsets (byte addresses = 4 * index)
  localparam logic [4:0] REG_COLLISION_FLAGS = 5'h00;
  localparam logic [4:0] REG_COLLISION_CLEAR = 5'h01;
  localparam logic [4:0] REG_MAP_CONTROL     = 5'h02;
  localparam logic [4:0] REG_CELL_SIZE       = 5'h03;
  localparam logic [4:0] REG_MAP_STEP        = 5'h04;
  localparam logic [4:0] REG_MAP_BASE        = 5'h05;
  localparam logic [4:0] REG_PLAYFIELD_3     = 5'h06;
  localparam logic [4:0] REG_BACKGROUND      = 5'h07;
  localparam logic [4:0] REG_PRIORITY_BASE   = 5'h08;
  localparam logic [4:0] REG_PALETTE_SELECT  = 5'h0C;
  localparam logic [4:0] REG_ENTRY_INDEX     = 5'h0D;
  localparam logic [4:0] REG_RED             = 5'h0E;
  localparam logic [4:0] REG_GREEN           = 5'h0F;
  localparam logic [4:0] REG_BLUE            = 5'h10;
  localparam logic [4:0] REG_MAP_ADDRESS     = 5'h11;
  // map control fields
  localparam int CTRL_MAP_ENABLE  = 0;
  localparam int CTRL_EXT_COLOUR  = 1;
  localparam int CTRL_NEXT_LINE   = 2;
  // control byte fields
  localparam int CB_PF_PAL_LSB   = 6;
  localparam int CB_OV_PAL_LSB   = 4;
  localparam int CB_COLLIDE      = 3;
  localparam int CB_RES_FLIP     = 2;
  localparam int CB_PRIO_LSB     = 0;
  // collision flag positions
  localparam int COL_PF0         = 4;
  localparam int COL_PF1         = 5;
  localparam int COL_PF23        = 6;
  localparam int COL_CELL        = 7;
  // reset values and limits
  localparam logic [7:0]  PRIORITY_RESET = 8'hFF;
  localparam logic [1:0]  DEFAULT_PF_PAL = 2'h0;
  localparam logic [1:0]  DEFAULT_OV_PAL = 2'h1;
  localparam logic [11:0] STEP_MAX       = 12'hFFF;
  localparam int          MIN_CELL_W     = 8;
  localparam int          MAX_CELL_W     = 32;
  localparam int          MAX_CELL_H     = 32;
  // playfield pixel class from the host display chain
  typedef enum logic [2:0] {
    PIX_BACKGROUND = 3'b000,
    PIX_PF0        = 3'b001,
    PIX_PF1        = 3'b010,
    PIX_PF2        = 3'b011,
    PIX_PF3        = 3'b100
  } pix_class_t;
endpackage

// *** core/attribute_map_palette_unit.sv ***
// attribute map cell processing, raster collisions and rgb palette port
// How it works
// - flag bits: players, pf0, pf1, pf2/3, cell
// - any collision_clear write zeroes all flags except those hit in that cycle
// - transparent overlay pixels never collide
// - collisions ignore display priority
// - cell size 8x1 up to 32x32
// - map address steps 0..4095 per cell line
// - four bytes per cell: pf0,pf1,pf2,control
// - control 7:6 playfield palette, else default_pf_pal_in
// - control 5:4 overlay palette, else default_ov_pal_in
// - cell palettes override display list defaults
// - control bit 3 enables cell collision
// - control bit 2 flips resolution
// - control 1:0 picks priority register
// - colour-clock: cell bytes replace pf0..pf2
// - hires pattern bit picks pf2 or pf3
// - pattern bit covers 1, 2 or 4 pixels
// - lit colour byte 2, extended-colour bit
// - colour-clock to hires two-pixel expansion
// - hires bit pair to colour-clock colour
// - four 256-entry palettes, 7-bit components
// - blue write increments index, select kept
// - priority bits put overlay over objects
// - red and green wait for blue, entry shows immediately
`timescale 1ns/10ps
module attribute_map_palette_unit
  import attr_map_pkg::*;
#(
  parameter int ADDR_W = 19
) (
  input  wire logic              clk_in,
  input  wire logic              nrst_in,
  // avalon-mm slave
  input  wire logic [4:0]        avs_address_in,
  input  wire logic              avs_read_in,
  input  wire logic              avs_write_in,
  input  wire logic [31:0]       avs_writedata_in,
  output logic [31:0]            avs_readdata_out,
  output logic                   avs_waitrequest_out,
  // host pixel stream, one pixel per cycle when valid
  input  wire logic              pix_valid_in,
  input  wire logic              line_start_in,
  input  wire logic              frame_start_in,
  input  wire logic              hires_in,
  input  wire logic [2:0]        pf_class_in,
  input  wire logic [1:0]        hires_bits_in,
  input  wire logic [3:0]        player_hit_in,
  input  wire logic [1:0]        default_pf_pal_in,
  input  wire logic [1:0]        default_ov_pal_in,
  input  wire logic [7:0]        default_priority_in,
  input  wire logic [7:0]        overlay_colour_in,
  input  wire logic              overlay_opaque_in,
  // cell bytes from video memory, byte 1 first
  input  wire logic [31:0]       cell_bytes_in,
  // outputs
  output logic [ADDR_W-1:0]      map_fetch_addr_out,
  output logic [7:0]             pf_colour_out,
  output logic [1:0]             pf_palette_out,
  output logic [1:0]             ov_palette_out,
  output logic                   overlay_on_top_out,
  output logic [20:0]            palette_rgb_out
);
  // fetch addresses narrower than a cell line step or wider than 24 bits make no sense
  if (ADDR_W < 12 || ADDR_W > 24) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end

  // registers
  logic [7:0]        collision_flags;
  logic [2:0]        map_control;
  logic [4:0]        cell_w_m1;
  logic [4:0]        cell_h_m1;
  logic [11:0]       map_step;
  logic [ADDR_W-1:0] map_base;
  logic [ADDR_W-1:0] line_addr;
  logic [7:0]        playfield_colour_3;
  logic [7:0]        background_colour_register;
  logic [7:0]        priority_reg [4];
  logic [1:0]        palette_select;
  logic [7:0]        palette_entry_index;
  logic [6:0]        red_component, green_component;
  logic [4:0]        col_cnt, row_cnt;
  logic [20:0]       palette_mem [1024];

  // bus decode
  wire bus_req = avs_read_in || avs_write_in;
  wire bus_wr = avs_write_in && !avs_waitrequest_out; // taken on the no-wait cycle only
  wire hit_clear = bus_wr && avs_address_in == REG_COLLISION_CLEAR;
  wire hit_blue  = bus_wr && avs_address_in == REG_BLUE;
  wire map_on    = map_control[CTRL_MAP_ENABLE];

  // cell fields
  wire [7:0] cell_pf0  = cell_bytes_in[7:0];
  wire [7:0] cell_pf1  = cell_bytes_in[15:8];
  wire [7:0] cell_pf2  = cell_bytes_in[23:16];
  wire [7:0] cell_ctrl = cell_bytes_in[31:24];
  wire [1:0] cell_prio = cell_ctrl[CB_PRIO_LSB +: 2];
  wire [3:0] cell_pals = cell_ctrl[CB_OV_PAL_LSB +: 4];            // pf then ov palette

  // palette choice per cell
  wire [1:0] next_pf_pal = map_on ? cell_ctrl[CB_PF_PAL_LSB +: 2]
                                  : DEFAULT_PF_PAL;
  wire [1:0] next_ov_pal = map_on ? cell_ctrl[CB_OV_PAL_LSB +: 2]
                                  : DEFAULT_OV_PAL;
  wire [7:0] prio_sel = map_on ? priority_reg[cell_prio]
                               : default_priority_in;
  wire       eff_hires = hires_in ^ (map_on & cell_ctrl[CB_RES_FLIP]);

  // hires pattern bit: pixel index scaled by cell width
  wire [2:0] pat_idx = (cell_w_m1 > 5'd15) ? col_cnt[4:2]
                     : (cell_w_m1 > 5'd7)  ? col_cnt[3:1] : col_cnt[2:0];
  wire       pat_bit = cell_pf0[3'd7 - pat_idx];
  wire [7:0] hires_bg = pat_bit ? playfield_colour_3 : cell_pf2;
  wire [7:0] lit_col  = map_control[CTRL_EXT_COLOUR] ? cell_pf1
                      : {background_colour_register[7:4], cell_pf1[3:0]};
  wire       cls_pf3  = pf_class_in == PIX_PF3;
  wire       cls_bg   = pf_class_in == PIX_BACKGROUND;

  // colour-clock source shown as hires: left/right halves
  function automatic logic cc_to_lit(input logic [2:0] c, input logic right);
    case (c)
      PIX_PF0:  cc_to_lit = right;
      PIX_PF1:  cc_to_lit = !right;
      PIX_PF2:  cc_to_lit = 1'b1;
      PIX_PF3:  cc_to_lit = 1'b1;
      default:  cc_to_lit = 1'b0;
    endcase
  endfunction

  // hires bit pair shown as colour clock
  function automatic logic [7:0] hr_to_cc(input logic [1:0] b, input logic [7:0] c0,
                                          input logic [7:0] c1, input logic [7:0] c2,
                                          input logic [7:0] c3);
    case (b)
      2'b00:   hr_to_cc = c0;
      2'b01:   hr_to_cc = c1;
      2'b10:   hr_to_cc = c2;
      default: hr_to_cc = c3;
    endcase
  endfunction

  // final playfield colour selection
  wire [7:0] cc_native = cls_pf3 ? playfield_colour_3
                       : pf_class_in == PIX_PF0 ? cell_pf0
                       : pf_class_in == PIX_PF1 ? cell_pf1
                       : pf_class_in == PIX_PF2 ? cell_pf2
                       : background_colour_register;
  wire       hr_lit_native = hires_bits_in[1];
  wire       hr_lit_forced = cc_to_lit(pf_class_in, col_cnt[0]);
  wire [7:0] cc_forced = hr_to_cc(hires_bits_in, cell_pf0, cell_pf1,
                                  cell_pf2, playfield_colour_3);
  wire [7:0] next_pf_colour =
      !map_on ? background_colour_register
    : (eff_hires && !hires_in) ? (hr_lit_forced ? lit_col : hires_bg)
    : eff_hires ? (hr_lit_native ? lit_col : hires_bg)
    : (!eff_hires && hires_in) ? cc_forced : cc_native;

  // overlay ordering against every player and playfield object present
  wire [3:0] pf_onehot = {cls_pf3, pf_class_in == PIX_PF2,
                          pf_class_in == PIX_PF1, pf_class_in == PIX_PF0};
  wire next_on_top = overlay_opaque_in &&
                     ((player_hit_in & ~prio_sel[3:0]) == 4'h0) &&
                     ((pf_onehot & ~prio_sel[7:4]) == 4'h0);

  // collision event vector, independent of priority
  wire [7:0] hit_vec = {map_on & cell_ctrl[CB_COLLIDE],
                        pf_class_in == PIX_PF2 || cls_pf3,
                        pf_class_in == PIX_PF1,
                        pf_class_in == PIX_PF0,
                        player_hit_in};
  wire [7:0] hits = (pix_valid_in && overlay_opaque_in) ? hit_vec : 8'h00;

  // map position counters
  wire last_col  = col_cnt == cell_w_m1;
  wire last_row  = row_cnt == cell_h_m1;
  wire [ADDR_W-1:0] step_ext = ADDR_W'(map_step);

  // register read mux
  logic [31:0] next_readdata;
  always_comb begin
    next_readdata = 32'h0000_0000;
    unique case (avs_address_in)
      REG_COLLISION_FLAGS: next_readdata = {24'h000000, collision_flags};
      REG_MAP_CONTROL:     next_readdata = {29'h0, map_control};
      REG_CELL_SIZE:       next_readdata = {22'h0, cell_h_m1, cell_w_m1};
      REG_MAP_STEP:        next_readdata = {20'h0, map_step};
      REG_PALETTE_SELECT:  next_readdata = {30'h0, palette_select};
      REG_ENTRY_INDEX:     next_readdata = {24'h0, palette_entry_index};
      REG_MAP_ADDRESS:     next_readdata = 32'(line_addr);
      default:             next_readdata = 32'h0000_0000;
    endcase
  end

  // bus handshake: waitrequest idles high so it can come from a flip-flop;
  // the price is one wait cycle on writes as well as reads
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= 32'h0000_0000;
    end else begin
      avs_waitrequest_out <= !(bus_req && avs_waitrequest_out);
      if (avs_read_in && avs_waitrequest_out) avs_readdata_out <= next_readdata;
    end
  end

  // software registers
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      map_control <= 3'h0;
      cell_w_m1 <= 5'h07;
      cell_h_m1 <= 5'h00;
      map_step <= 12'h000;
      map_base <= '0;
      playfield_colour_3 <= 8'h00;
      background_colour_register <= 8'h00;
      for (int i = 0; i < 4; i++) priority_reg[i] <= PRIORITY_RESET;
      palette_select <= 2'h0;
      palette_entry_index <= 8'h00;
      red_component <= 7'h00;
      green_component <= 7'h00;
    end else if (bus_wr) begin
      unique case (avs_address_in)
        REG_MAP_CONTROL: map_control <= avs_writedata_in[2:0];
        REG_CELL_SIZE: begin
          cell_w_m1 <= (avs_writedata_in[4:0] < 5'd7) ? 5'd7 : avs_writedata_in[4:0];
          cell_h_m1 <= avs_writedata_in[9:5];
        end
        REG_MAP_STEP:       map_step <= avs_writedata_in[11:0] & STEP_MAX;
        REG_MAP_BASE:       map_base <= avs_writedata_in[ADDR_W-1:0];
        REG_PLAYFIELD_3:    playfield_colour_3 <= avs_writedata_in[7:0];
        REG_BACKGROUND:     background_colour_register <= avs_writedata_in[7:0];
        5'h08, 5'h09, 5'h0A, 5'h0B:
          priority_reg[avs_address_in[1:0]] <= avs_writedata_in[7:0];
        REG_PALETTE_SELECT: palette_select <= avs_writedata_in[1:0];
        REG_ENTRY_INDEX:    palette_entry_index <= avs_writedata_in[7:0];
        REG_RED:            red_component <= avs_writedata_in[7:1];
        REG_GREEN:          green_component <= avs_writedata_in[7:1];
        REG_BLUE:           palette_entry_index <= palette_entry_index + 8'h01;
        default: ;
      endcase
    end
  end

  // palette store written straight from the bus, no shadow copy
  always_ff @(posedge clk_in) begin
    if (hit_blue)
      palette_mem[{palette_select, palette_entry_index}] <=
        {red_component, green_component, avs_writedata_in[7:1]};
  end

  // sticky collision flags, set beats clear
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) collision_flags <= 8'h00;
    else collision_flags <= (hit_clear ? 8'h00 : collision_flags) | hits;
  end

  // cell walk and map fetch address
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      col_cnt <= 5'h00;
      row_cnt <= 5'h00;
      line_addr <= '0;
      map_fetch_addr_out <= '0;
    end else if (frame_start_in) begin
      col_cnt <= 5'h00;
      row_cnt <= 5'h00;
      line_addr <= map_base;
      map_fetch_addr_out <= map_base;
    end else if (line_start_in) begin
      col_cnt <= 5'h00;
      row_cnt <= last_row ? 5'h00 : row_cnt + 5'h01;
      if (last_row) begin
        line_addr <= line_addr + step_ext;
        map_fetch_addr_out <= line_addr + step_ext;
      end else map_fetch_addr_out <= line_addr;
    end else if (pix_valid_in) begin
      col_cnt <= last_col ? 5'h00 : col_cnt + 5'h01;
      if (last_col) map_fetch_addr_out <= map_fetch_addr_out + ADDR_W'(4);
    end
  end

  // pixel outputs, one register stage; palette read uses overlay or pf palette
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pf_colour_out <= 8'h00;
      pf_palette_out <= DEFAULT_PF_PAL;
      ov_palette_out <= DEFAULT_OV_PAL;
      overlay_on_top_out <= 1'b0;
      palette_rgb_out <= 21'h000000;
    end else if (pix_valid_in) begin
      pf_colour_out <= next_pf_colour;
      pf_palette_out <= map_on ? next_pf_pal : default_pf_pal_in;
      ov_palette_out <= map_on ? next_ov_pal : default_ov_pal_in;
      overlay_on_top_out <= next_on_top;
      palette_rgb_out <= next_on_top
        ? palette_mem[{(map_on ? next_ov_pal : default_ov_pal_in), overlay_colour_in}]
        : palette_mem[{(map_on ? next_pf_pal : default_pf_pal_in), next_pf_colour}];
    end
  end

  // assertions
  a_clear_zeroes: assert property (@(posedge clk_in) disable iff (!nrst_in)
    hit_clear && !pix_valid_in |=> collision_flags == 8'h00)
    else $error("clear write left flags set");
  a_flags_sticky: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !$past(hit_clear) && $past(collision_flags) != 8'h00 |->
      (collision_flags & $past(collision_flags)) == $past(collision_flags))
    else $error("collision flag dropped without clear");
  a_transparent_quiet: assert property (@(posedge clk_in) disable iff (!nrst_in)
    !overlay_opaque_in && !hit_clear |=> collision_flags == $past(collision_flags))
    else $error("transparent pixel set a flag");
  a_blue_increments: assert property (@(posedge clk_in) disable iff (!nrst_in)
    hit_blue |=> palette_entry_index == $past(palette_entry_index) + 8'h01
      && palette_select == $past(palette_select))
    else $error("blue write did not step index");
  a_red_keeps_index: assert property (@(posedge clk_in) disable iff (!nrst_in)
    bus_wr && avs_address_in == REG_RED |=> $stable(palette_entry_index))
    else $error("red write moved index");
  a_player_hit: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pix_valid_in && overlay_opaque_in && player_hit_in[0] |=> collision_flags[0])
    else $error("player 0 collision lost");
  a_cell_hit: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pix_valid_in && overlay_opaque_in && map_on && cell_ctrl[CB_COLLIDE]
      |=> collision_flags[COL_CELL])
    else $error("cell collision lost");
  a_cell_palettes: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pix_valid_in && map_on |=> {pf_palette_out, ov_palette_out} == $past(cell_pals))
    else $error("cell palettes not applied");
  a_fetch_step: assert property (@(posedge clk_in) disable iff (!nrst_in)
    pix_valid_in && !line_start_in && !frame_start_in && last_col |=>
      map_fetch_addr_out == $past(map_fetch_addr_out) + ADDR_W'(4))
    else $error("fetch address did not step one cell");
  a_step_line: assert property (@(posedge clk_in) disable iff (!nrst_in)
    line_start_in && !frame_start_in && last_row |=>
      line_addr == $past(line_addr) + $past(step_ext))
    else $error("map step not applied");
endmodule // attribute_map_palette_unit

// *** verif/video_mem_model.sv ***
// video memory model that answers map fetches with one stored cell
`timescale 1ns/10ps
module video_mem_model (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic [18:0] addr_in,
  input  wire logic [31:0] fill_in,
  output logic      [31:0] cell_bytes_out
);
  // every cell holds the same four bytes, so fetch latency cannot skew a check
  // during reset the data lines show a fixed filler pattern
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cell_bytes_out <= 32'h5A5A_A5A5;
    end else begin
      cell_bytes_out <= fill_in;
    end
  end
endmodule // video_mem_model

// *** verif/attribute_map_palette_unit_test.sv ***
// register and pixel tests for the attribute map and palette unit
`timescale 1ns/10ps
module attribute_map_palette_unit_test;
  import attr_map_pkg::*;
  logic        clk_in, nrst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [4:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, cell_bytes_in, fill, q;
  logic        pix_valid_in, line_start_in, frame_start_in, hires_in, overlay_opaque_in;
  logic        overlay_on_top_out;
  logic [2:0]  pf_class_in;
  logic [1:0]  hires_bits_in, pf_palette_out, ov_palette_out;
  logic [1:0]  default_pf_pal_in, default_ov_pal_in;
  logic [3:0]  player_hit_in;
  logic [7:0]  default_priority_in, overlay_colour_in, pf_colour_out;
  logic [18:0] map_fetch_addr_out;
  logic [20:0] palette_rgb_out;
  int          err_total, checks, cyc;

  attribute_map_palette_unit dut (.clk_in(clk_in), .nrst_in(nrst_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
    .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
    .pix_valid_in(pix_valid_in), .line_start_in(line_start_in),
    .frame_start_in(frame_start_in), .hires_in(hires_in), .pf_class_in(pf_class_in),
    .hires_bits_in(hires_bits_in), .player_hit_in(player_hit_in),
    .default_pf_pal_in(default_pf_pal_in), .default_ov_pal_in(default_ov_pal_in),
    .default_priority_in(default_priority_in), .overlay_colour_in(overlay_colour_in),
    .overlay_opaque_in(overlay_opaque_in), .cell_bytes_in(cell_bytes_in),
    .map_fetch_addr_out(map_fetch_addr_out), .pf_colour_out(pf_colour_out),
    .pf_palette_out(pf_palette_out), .ov_palette_out(ov_palette_out),
    .overlay_on_top_out(overlay_on_top_out), .palette_rgb_out(palette_rgb_out));

  video_mem_model mem (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(map_fetch_addr_out),
    .fill_in(fill), .cell_bytes_out(cell_bytes_in));

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // hang guard: the whole sequence needs well under a few thousand cycles
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      end_of_test();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one avalon transfer; the request is held until a rising edge sees
  // waitrequest low, read data is taken at that edge, only the hang guard ends a wait
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    avs_address_in   <= a;
    avs_writedata_in <= d;
    avs_write_in     <= wr;
    avs_read_in      <= !wr;
    @(posedge clk_in);
    while (avs_waitrequest_out !== 1'b0) @(posedge clk_in);
    q = avs_readdata_out;
    avs_write_in <= 1'b0;
    avs_read_in  <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask

  // one valid pixel; outputs show it one edge later
  task automatic pix(input logic [2:0] c, input logic [3:0] p, input logic op);
    pf_class_in       <= c;
    player_hit_in     <= p;
    overlay_opaque_in <= op;
    pix_valid_in      <= 1'b1;
    @(posedge clk_in);
    pix_valid_in <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    logic [7:0] flag_bit [4];
    flag_bit = '{8'h10, 8'h20, 8'h40, 8'h40};
    err_total = 0; checks = 0; cyc = 0; nrst_in = 1'b0; fill = 32'hB833_2211;
    avs_read_in = 1'b0; avs_write_in = 1'b0; avs_address_in = 5'h00;
    avs_writedata_in = 32'h0; pix_valid_in = 1'b0; line_start_in = 1'b0;
    frame_start_in = 1'b0; hires_in = 1'b0; pf_class_in = 3'h0; hires_bits_in = 2'h0;
    player_hit_in = 4'h0; default_priority_in = 8'h00; overlay_colour_in = 8'h42;
    overlay_opaque_in = 1'b0; default_pf_pal_in = 2'h1; default_ov_pal_in = 2'h2;
    repeat (4) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    // reset state, write-only and unmapped places
    rd(REG_COLLISION_FLAGS, 32'h0);
    rd(REG_CELL_SIZE, 32'h0000_0007);
    rd(REG_COLLISION_CLEAR, 32'h0);
    rd(5'h1F, 32'h0);
    $display("test reset done");
    // each playfield flag source and players 1 and 3, overlay kept behind everything by priority 00
    for (int c = 1; c < 5; c++) begin
      bus(1'b1, REG_COLLISION_CLEAR, 32'h0000_005A);
      pix(c[2:0], 4'h0, 1'b1);
      rd(REG_COLLISION_FLAGS, {24'h0, flag_bit[c-1]});
    end
    bus(1'b1, REG_COLLISION_CLEAR, 32'h0000_00FF);
    pix(PIX_BACKGROUND, 4'hA, 1'b1);
    pix(PIX_PF0, 4'h5, 1'b0);
    pix(PIX_BACKGROUND, 4'h0, 1'b1);
    rd(REG_COLLISION_FLAGS, 32'h0000_000A);
    chk({pf_palette_out, ov_palette_out}, 4'h6);
    bus(1'b1, REG_COLLISION_CLEAR, 32'h0);
    rd(REG_COLLISION_FLAGS, 32'h0);
    $display("test collisions done");
    // palette port: select, index, red, green, blue in order
    bus(1'b1, REG_PALETTE_SELECT, 32'h2);
    bus(1'b1, REG_ENTRY_INDEX, 32'hFE);
    bus(1'b1, REG_RED, 32'h81);
    bus(1'b1, REG_GREEN, 32'h41);
    rd(REG_ENTRY_INDEX, 32'hFE);
    bus(1'b1, REG_BLUE, 32'h21);
    rd(REG_ENTRY_INDEX, 32'hFF);
    bus(1'b1, REG_BLUE, 32'h11);
    rd(REG_ENTRY_INDEX, 32'h00);
    rd(REG_PALETTE_SELECT, 32'h2);
    bus(1'b1, REG_ENTRY_INDEX, 32'h22);
    bus(1'b1, REG_RED, 32'h03);
    bus(1'b1, REG_GREEN, 32'h05);
    bus(1'b1, REG_BLUE, 32'h07);
    $display("test palette done");
    // active map: cell palettes, colours, priority register 0 and cell collision
    bus(1'b1, REG_PRIORITY_BASE, 32'hDF);
    bus(1'b1, REG_CELL_SIZE, 32'h0);
    bus(1'b1, REG_MAP_BASE, 32'h0);
    bus(1'b1, REG_MAP_STEP, 32'h123);
    bus(1'b1, REG_PLAYFIELD_3, 32'h5C);
    bus(1'b1, REG_MAP_CONTROL, 32'h1);
    default_priority_in <= 8'hFF;
    frame_start_in <= 1'b1;
    @(posedge clk_in);
    frame_start_in <= 1'b0;
    line_start_in  <= 1'b1;
    @(posedge clk_in);
    line_start_in <= 1'b0;
    repeat (4) pix(PIX_PF1, 4'h0, 1'b1);
    chk(pf_colour_out, 8'h22);
    chk(pf_palette_out, 2'h2);
    chk(ov_palette_out, 2'h3);
    chk(overlay_on_top_out, 1'b0);
    chk(palette_rgb_out, 32'h0000_4103);
    chk(map_fetch_addr_out, 32'h0000_0123);
    rd(REG_COLLISION_FLAGS, 32'h0000_00A0);
    rd(REG_MAP_ADDRESS, 32'h0000_0123);
    // native hires: pattern bits pick pf2 or pf3, lit pixels take byte 2
    hires_in <= 1'b1;
    pix(PIX_BACKGROUND, 4'h0, 1'b0);
    chk(pf_colour_out, 8'h33);
    hires_bits_in <= 2'b10;
    pix(PIX_BACKGROUND, 4'h0, 1'b0);
    chk(pf_colour_out, 8'h02);
    hires_bits_in <= 2'b00;
    repeat (2) pix(PIX_BACKGROUND, 4'h0, 1'b0);
    chk(pf_colour_out, 8'h5C);
    chk(map_fetch_addr_out, 32'h0000_0127);
    // the cell flips resolution: colour clock shown as hires, then hires as colour clock
    fill <= 32'hBC33_2211;
    hires_in <= 1'b0;
    @(posedge clk_in);
    pix(PIX_PF0, 4'h0, 1'b0);
    chk(pf_colour_out, 8'h33);
    pix(PIX_PF0, 4'h0, 1'b0);
    chk(pf_colour_out, 8'h02);
    hires_in <= 1'b1;
    hires_bits_in <= 2'b01;
    pix(PIX_BACKGROUND, 4'h0, 1'b0);
    chk(pf_colour_out, 8'h22);
    hires_bits_in <= 2'b11;
    pix(PIX_BACKGROUND, 4'h0, 1'b0);
    chk(pf_colour_out, 8'h5C);
    // extended colour keeps all eight bits of the lit colour
    fill <= 32'hB833_2211;
    bus(1'b1, REG_MAP_CONTROL, 32'h3);
    hires_bits_in <= 2'b10;
    pix(PIX_BACKGROUND, 4'h0, 1'b0);
    chk(pf_colour_out, 8'h22);
    $display("test attribute map done");
    end_of_test();
  end
endmodule // attribute_map_palette_unit_test
